//--- verilog/dsl_config.sv
/*
 demodulator and sync/length configuration registers with a classic
 wishbone slave, channel selection, pll time constants, timer prescaler
 and minimum packet length filter.
 assumes receiver datapath inputs are on ref_clk; carrier_in is a pin.
*/
// Notes on behaviour
// [RQ1] combine code 00: follow the stronger of i and q every cycle
// [RQ2] code 01: pick stronger channel, then hold it while communication lasts
// [RQ3] code 10: combine i and q; code 11 reserved, acts like 00
// [RQ4] combine codes apply only with the fixed-channel bit clear
// [RQ5] fixed-channel set: low combine bit 1 locks q, 0 locks i
// [RQ6] software sets fixed bit and zero combine when pins link secure element
// [RQ7] even bit 0: one tick per 2*prescale+1 carrier edges
// [RQ8] even bit 1: one tick per 2*prescale+2 edges; bit resets to 0
// [RQ9] receive tau field drives pll during reception; 00 freezes it
// [RQ10] burst tau field, two low bits, drives pll during burst
// [RQ11] sync length code n expects n leading zero bytes before b2 4d
// [RQ12] accept packet only if length is at least four times minimum field
// [RQ13] at 106 kbit with sync detect off, minimum check is skipped
// [RQ14] reset loads 4d and 00; both registers read and write fully
`timescale 1ns/1ns
`include "dsl_params.svh"
module dsl_config #(
   parameter int ADDR_W = 10
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic carrier_in,
   input wire logic [7:0] i_strength,
   input wire logic [7:0] q_strength,
   input wire logic comm_active,
   input wire logic pkt_done,
   input wire logic [8:0] pkt_len,
   output logic use_q_channel,
   output logic combine_iq,
   output logic [1:0] rx_pll_tau,
   output logic rx_pll_freeze,
   output logic [1:0] burst_pll_tau,
   output logic [2:0] sync_byte_count,
   output logic pkt_accept,
   output logic pkt_discard,
   output logic timer_tick
);
   localparam dsl_pkg::dsl_state_t RST_S = '{
      demod: `DSL_RST_DEMOD,
      synclen: `DSL_RST_SYNC,
      rxctx: `DSL_RST_RXCTX,
      presc: `DSL_RST_PRESC,
      rx_tau: 2'h3,
      burst_tau: 2'h1,
      sync_cnt: `DSL_SYNC_BASE,
      default: '0
   };

   logic [1:0] rsync;
   logic sys_rst_n;
   dsl_pkg::dsl_state_t s;
   dsl_pkg::dsl_state_t next_s;
   logic req;
   logic [7:0] idx;
   logic fix;
   logic stronger_q;
   logic skip_len;
   logic len_ok;
   logic [8:0] min4;
   logic carrier_edge;
   logic tick;
   dsl_pkg::dsl_combine_t mode;

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rsync <= 2'h0;
      end else begin
         rsync <= {rsync[0], 1'h1};
      end
   end
   assign sys_rst_n = rsync[1];

   // decoded views of the current state
   assign req = wb_cyc_i & wb_stb_i & ~s.ack;
   assign idx = wb_adr_i[9:2];
   assign fix = s.demod[`DSL_F_FIX];
   assign mode = dsl_pkg::dsl_combine_t'(s.demod[`DSL_F_COMB]);
   assign stronger_q = q_strength > i_strength;
   assign min4 = {1'h0, s.synclen[`DSL_F_MINLEN], 2'h0};
   assign skip_len = s.rxctx[`DSL_F_RATE106] & ~s.rxctx[`DSL_F_DETECT]; // RQ13
   assign len_ok = skip_len | (pkt_len >= min4); // RQ12
   assign carrier_edge = s.car_sync[1] & ~s.car_prev;

   // next state: bus slave, channel choice, pll and length filter
   always_comb begin
      next_s = s;
      next_s.ack = 1'h0;
      next_s.accept = 1'h0;
      next_s.discard = 1'h0;
      // carrier pin: second flop only feeds the edge detector
      next_s.car_sync = {s.car_sync[0], carrier_in};
      next_s.car_prev = s.car_sync[1];
      // single-cycle answer; unmapped reads give zero, writes dropped
      if (req) begin
         next_s.ack = 1'h1;
         next_s.rdata = 32'h0000_0000;
         case (idx)
            `DSL_IDX_DEMOD: next_s.rdata[7:0] = s.demod; // RQ14
            `DSL_IDX_SYNC: next_s.rdata[7:0] = s.synclen; // RQ14
            `DSL_IDX_RXCTX: next_s.rdata[1:0] = s.rxctx;
            `DSL_IDX_PRESC: next_s.rdata[11:0] = s.presc;
            `DSL_IDX_STAT: next_s.rdata = {8'h00, s.n_dis, s.n_acc, 5'h00, s.frozen, s.combine, s.use_q};
            default: next_s.rdata = 32'h0000_0000;
         endcase
         if (wb_we_i) begin
            case (idx)
               `DSL_IDX_DEMOD: begin
                  if (wb_sel_i[0]) next_s.demod = wb_dat_i[7:0]; // RQ14
               end
               `DSL_IDX_SYNC: begin
                  if (wb_sel_i[0]) next_s.synclen = wb_dat_i[7:0]; // RQ14
               end
               `DSL_IDX_RXCTX: begin
                  if (wb_sel_i[0]) next_s.rxctx = wb_dat_i[1:0];
               end
               `DSL_IDX_PRESC: begin
                  if (wb_sel_i[0]) next_s.presc[7:0] = wb_dat_i[7:0];
                  if (wb_sel_i[1]) next_s.presc[11:8] = wb_dat_i[11:8];
               end
               default: begin
                  next_s.presc = s.presc;
               end
            endcase
         end
      end
      // channel choice; fixed bit overrides the combine field
      next_s.frozen = 1'h0;
      next_s.combine = 1'h0;
      if (fix) begin
         next_s.use_q = s.demod[`DSL_F_COMB_LO]; // RQ4 RQ5
      end else begin
         case (mode)
            dsl_pkg::DSL_FREEZE: begin
               // pick until communication runs, then hold the pick
               next_s.frozen = comm_active; // RQ2
               if (!s.frozen) next_s.use_q = stronger_q; // RQ2
            end
            dsl_pkg::DSL_COMBINE: begin
               next_s.combine = 1'h1; // RQ3
               next_s.use_q = 1'h0;
            end
            // reserved code falls back to the safe dynamic pick
            default: next_s.use_q = stronger_q; // RQ1 RQ3
         endcase
      end
      // pll constants and sync preamble length
      next_s.rx_tau = s.demod[`DSL_F_TAUR]; // RQ9
      next_s.freeze = (s.demod[`DSL_F_TAUR] == 2'h0); // RQ9
      next_s.burst_tau = s.demod[`DSL_F_TAUS]; // RQ10
      next_s.sync_cnt = `DSL_SYNC_BASE + {1'h0, s.synclen[`DSL_F_SYNCLEN]}; // RQ11
      // length filter; short packets pulse pkt_discard and bump a count
      if (pkt_done) begin
         next_s.accept = len_ok; // RQ12
         next_s.discard = ~len_ok; // RQ12
         if (len_ok) begin
            next_s.n_acc = s.n_acc + 8'h01;
         end else begin
            next_s.n_dis = s.n_dis + 8'h01;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         s <= RST_S; // RQ14
      end else begin
         s <= next_s;
      end
   end

   // timer divider counts synchronised carrier edges
   dsl_prescaler u_psc (
      .ref_clk(ref_clk),
      .rst_n(sys_rst_n),
      .carrier_edge(carrier_edge),
      .prescale(s.presc),
      .even_sel(s.demod[`DSL_F_EVEN]), // RQ7 RQ8
      .tick(tick)
   );

   // outputs straight from state flops
   assign wb_ack_o = s.ack;
   assign wb_dat_o = s.rdata;
   assign use_q_channel = s.use_q;
   assign combine_iq = s.combine;
   assign rx_pll_tau = s.rx_tau;
   assign rx_pll_freeze = s.freeze;
   assign burst_pll_tau = s.burst_tau;
   assign sync_byte_count = s.sync_cnt;
   assign pkt_accept = s.accept;
   assign pkt_discard = s.discard;
   assign timer_tick = tick;

   // helper: carrier edges since last tick, and whether config moved
   logic [12:0] h_edges;
   logic h_seen;
   logic h_chg;
   logic [12:0] h_expect;
   assign h_expect = {s.presc, 1'h0} + 13'h0001 + {12'h000, s.demod[`DSL_F_EVEN]};
   always_ff @(posedge ref_clk or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         h_edges <= 13'h0000;
         h_seen <= 1'h0;
         h_chg <= 1'h0;
      end else begin
         if (tick) begin
            h_edges <= {12'h000, carrier_edge};
            h_seen <= 1'h1;
            h_chg <= 1'h0;
         end else begin
            h_edges <= h_edges + {12'h000, carrier_edge};
            if (next_s.presc != s.presc || next_s.demod[`DSL_F_EVEN] != s.demod[`DSL_F_EVEN]) h_chg <= 1'h1;
         end
      end
   end

   // checks on the configuration outputs
   a_dynamic_pick: assert property (@(posedge ref_clk) disable iff (!sys_rst_n) // RQ1
      (!fix && mode == dsl_pkg::DSL_DYNAMIC) |=> (use_q_channel == $past(stronger_q)))
      else $error("dynamic mode did not follow stronger channel");
   a_freeze_hold: assert property (@(posedge ref_clk) disable iff (!sys_rst_n) // RQ2
      (!fix && mode == dsl_pkg::DSL_FREEZE && s.frozen) |=> $stable(use_q_channel))
      else $error("frozen channel choice changed");
   a_combine_mode: assert property (@(posedge ref_clk) disable iff (!sys_rst_n) // RQ3
      (!fix && mode == dsl_pkg::DSL_COMBINE) |=> (combine_iq && !use_q_channel))
      else $error("combine mode not applied");
   a_fix_gates_combine: assert property (@(posedge ref_clk) disable iff (!sys_rst_n) // RQ4
      fix |=> !combine_iq)
      else $error("combine active with fixed channel");
   a_fix_lock: assert property (@(posedge ref_clk) disable iff (!sys_rst_n) // RQ5
      fix |=> (use_q_channel == $past(s.demod[`DSL_F_COMB_LO])))
      else $error("fixed channel not locked to low combine bit");
   a_tick_period: assert property (@(posedge ref_clk) disable iff (!sys_rst_n) // RQ7 RQ8
      (tick && h_seen && !h_chg) |-> (h_edges == h_expect))
      else $error("timer tick period wrong");
   a_pll_freeze: assert property (@(posedge ref_clk) disable iff (!sys_rst_n) // RQ9
      1'h1 |=> (rx_pll_tau == $past(s.demod[`DSL_F_TAUR])) && (rx_pll_freeze == (rx_pll_tau == 2'h0)))
      else $error("receive pll constant or freeze wrong");
   a_burst_tau: assert property (@(posedge ref_clk) disable iff (!sys_rst_n) // RQ10
      $changed(s.demod[`DSL_F_TAUS]) |=> (burst_pll_tau == $past(s.demod[`DSL_F_TAUS])))
      else $error("burst pll constant not applied");
   a_sync_count: assert property (@(posedge ref_clk) disable iff (!sys_rst_n) // RQ11
      1'h1 |=> (sync_byte_count == 3'h2 + {1'h0, $past(s.synclen[`DSL_F_SYNCLEN])}))
      else $error("sync byte count wrong");
   a_len_filter: assert property (@(posedge ref_clk) disable iff (!sys_rst_n) // RQ12
      (pkt_done && !skip_len) |=> (pkt_accept == ($past(pkt_len) >= $past(min4))) && (pkt_discard != pkt_accept))
      else $error("minimum length filter wrong");
   a_len_skip: assert property (@(posedge ref_clk) disable iff (!sys_rst_n) // RQ13
      (pkt_done && skip_len) |=> (pkt_accept && !pkt_discard))
      else $error("length check not skipped");
   a_reset_values: assert property (@(posedge ref_clk) // RQ14
      $rose(sys_rst_n) |-> (s.demod == `DSL_RST_DEMOD && s.synclen == `DSL_RST_SYNC))
      else $error("register reset values wrong");
   a_ack_single: assert property (@(posedge ref_clk) disable iff (!sys_rst_n)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");

   // main scenarios
   c_freeze_used: cover property (@(posedge ref_clk) disable iff (!sys_rst_n) s.frozen ##1 s.frozen);
   c_combine_used: cover property (@(posedge ref_clk) disable iff (!sys_rst_n) combine_iq);
   c_pkt_discard: cover property (@(posedge ref_clk) disable iff (!sys_rst_n) pkt_discard);
   c_tick_checked: cover property (@(posedge ref_clk) disable iff (!sys_rst_n) tick && h_seen && !h_chg);
endmodule // dsl_config

//--- verilog/dsl_params.svh
/*
 demodulator and sync/length configuration constants: register indices,
 field ranges and reset values.
 assumes inclusion by bare name from the design files only.
*/
`ifndef DSL_PARAMS_SVH
`define DSL_PARAMS_SVH
// register indices; byte address is four times the index
`define DSL_IDX_DEMOD 8'h19
`define DSL_IDX_SYNC 8'h1a
`define DSL_IDX_RXCTX 8'h20
`define DSL_IDX_PRESC 8'h21
`define DSL_IDX_STAT 8'h22
// reset values
`define DSL_RST_DEMOD 8'h4d
`define DSL_RST_SYNC 8'h00
`define DSL_RST_RXCTX 2'h0
`define DSL_RST_PRESC 12'h000
// demodulator_control fields
`define DSL_F_COMB 7:6
`define DSL_F_COMB_LO 6
`define DSL_F_FIX 5
`define DSL_F_EVEN 4
`define DSL_F_TAUR 3:2
`define DSL_F_TAUS 1:0
// sync_and_min_length fields
`define DSL_F_SYNCLEN 7:6
`define DSL_F_MINLEN 5:0
// rx context fields
`define DSL_F_DETECT 0
`define DSL_F_RATE106 1
// sync preamble: two fixed bytes plus one leading zero byte per code step
`define DSL_SYNC_BASE 3'h2
`endif

//--- verilog/dsl_pkg.sv
/*
 types shared by the configuration block and its timer prescaler.
 assumes dsl_params.svh for the constants.
*/
package dsl_pkg;
   // channel use when the fixed-channel bit is clear
   typedef enum logic [1:0] {
      DSL_DYNAMIC = 2'h0,
      DSL_FREEZE = 2'h1,
      DSL_COMBINE = 2'h2,
      DSL_RESERVED = 2'h3
   } dsl_combine_t;

   typedef struct packed {
      logic [12:0] cnt;
      logic tick;
   } dsl_psc_t;

   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic [7:0] demod;
      logic [7:0] synclen;
      logic [1:0] rxctx;
      logic [11:0] presc;
      logic [1:0] car_sync;
      logic car_prev;
      logic frozen;
      logic use_q;
      logic combine;
      logic [1:0] rx_tau;
      logic freeze;
      logic [1:0] burst_tau;
      logic [2:0] sync_cnt;
      logic accept;
      logic discard;
      logic [7:0] n_acc;
      logic [7:0] n_dis;
   } dsl_state_t;
endpackage

//--- verilog/dsl_prescaler.sv
/*
 timer prescaler: one tick per 2*p+1 or 2*p+2 carrier edges.
 assumes carrier_edge is a one-cycle pulse already in the ref_clk domain.
*/
`timescale 1ns/1ns
`include "dsl_params.svh"
module dsl_prescaler (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic carrier_edge,
   input wire logic [11:0] prescale,
   input wire logic even_sel,
   output logic tick
);
   dsl_pkg::dsl_psc_t s;
   dsl_pkg::dsl_psc_t next_s;
   logic [12:0] last;

   // last index of the period; the even bit stretches it by one edge
   always_comb begin
      last = {prescale, 1'h0} + {12'h000, even_sel};
      next_s = s;
      next_s.tick = 1'h0;
      if (carrier_edge) begin
         // >= so a shrinking prescale value never runs away
         if (s.cnt >= last) begin
            next_s.cnt = 13'h0000;
            next_s.tick = 1'h1;
         end else begin
            next_s.cnt = s.cnt + 13'h0001;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick = s.tick;
endmodule // dsl_prescaler

//--- verif/tb_dsl_config.sv
/*
 self-checking bench for the demodulator and sync/length configuration block.
 assumes dsl_config answers a classic wishbone request one cycle after taking it.
*/
`timescale 1ns/1ns
module tb_dsl_config;
   localparam logic [9:0] A_DEMOD = 10'h064;
   localparam logic [9:0] A_SYNC = 10'h068;
   localparam logic [9:0] A_RXCTX = 10'h080;
   localparam logic [9:0] A_PRESC = 10'h084;
   localparam logic [9:0] A_STAT = 10'h088;
   localparam logic [9:0] A_NONE = 10'h3fc;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [9:0] wb_adr_i = 10'h000;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic carrier_in = 1'b0;
   logic [7:0] i_strength = 8'h00;
   logic [7:0] q_strength = 8'h00;
   logic comm_active = 1'b0;
   logic pkt_done = 1'b0;
   logic [8:0] pkt_len = 9'h000;
   logic use_q_channel, combine_iq, rx_pll_freeze, pkt_accept, pkt_discard, timer_tick;
   logic [1:0] rx_pll_tau, burst_pll_tau;
   logic [2:0] sync_byte_count;
   logic [2:0] cdiv = 3'h0;
   logic [31:0] rd;
   int num_errors = 0;
   int tests_run = 0;

   dsl_config #(.ADDR_W(10)) u_dut (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .carrier_in, .i_strength, .q_strength,
      .comm_active, .pkt_done, .pkt_len, .use_q_channel, .combine_iq, .rx_pll_tau, .rx_pll_freeze,
      .burst_pll_tau, .sync_byte_count, .pkt_accept, .pkt_discard, .timer_tick);

   always #5 ref_clk = ~ref_clk;

   // carrier stand-in: one rising edge every eight cycles, slow enough for the synchroniser
   always @(posedge ref_clk) begin
      cdiv <= cdiv + 3'h1;
      carrier_in <= cdiv[2];
   end

   task automatic end_of_test();
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic overrun(input string what);
      num_errors++;
      $display("BAD %s expected pulse seen none", what);
      end_of_test();
   endtask

   // one classic cycle; request held until ack is sampled high
   task automatic wb(input logic we, input logic [9:0] adr, input logic [3:0] sel,
                     input logic [31:0] wdat, output logic [31:0] rdat);
      int n;
      @(posedge ref_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= wdat;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      if (n >= 20 && wb_ack_o !== 1'b1) overrun("wb_ack_o");
   endtask

   task automatic wr(input logic [9:0] adr, input logic [31:0] d);
      wb(1'b1, adr, 4'h3, d, rd);
   endtask

   task automatic rdchk(input string what, input logic [9:0] adr, input logic [31:0] exp);
      wb(1'b0, adr, 4'hf, 32'h0000_0000, rd);
      chk(what, exp, rd);
   endtask

   // let register and input changes reach the config outputs
   task automatic settle();
      repeat (3) @(posedge ref_clk);
      #1;
   endtask

   task automatic chan(input logic [31:0] q, input logic [31:0] comb);
      settle();
      chk("use_q_channel", q, {31'h0, use_q_channel});
      chk("combine_iq", comb, {31'h0, combine_iq});
   endtask

   task automatic pkt(input logic [8:0] len, input logic acc);
      @(posedge ref_clk);
      pkt_done <= 1'b1;
      pkt_len <= len;
      @(posedge ref_clk);
      pkt_done <= 1'b0;
      #1;
      chk("pkt_accept", {31'h0, acc}, {31'h0, pkt_accept});
      chk("pkt_discard", {31'h0, !acc}, {31'h0, pkt_discard});
   endtask

   // the last of three gaps is measured, so a period cut by the write is skipped
   task automatic tick_gap(input logic [31:0] exp);
      int n;
      for (int k = 0; k < 3; k++) begin
         n = 0;
         do begin
            @(posedge ref_clk);
            n++;
         end while (timer_tick !== 1'b1 && n < 400);
         if (n >= 400) overrun("timer_tick");
      end
      chk("tick_gap", exp, n);
   endtask

   initial begin
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge ref_clk);
      #1;
      chk("rx_pll_tau", 32'h0000_0003, {30'h0, rx_pll_tau});
      chk("burst_pll_tau", 32'h0000_0001, {30'h0, burst_pll_tau});
      chk("sync_byte_count", 32'h0000_0002, {29'h0, sync_byte_count});
      rdchk("demodulator_control", A_DEMOD, 32'h0000_004d);
      rdchk("sync_and_min_length", A_SYNC, 32'h0000_0000);
      wr(A_DEMOD, 32'h0000_00ff);
      rdchk("demodulator_control", A_DEMOD, 32'h0000_00ff);
      wr(A_SYNC, 32'h0000_00ff);
      rdchk("sync_and_min_length", A_SYNC, 32'h0000_00ff);
      // a write with no lane enabled must leave the register alone
      wb(1'b1, A_SYNC, 4'h0, 32'h0000_0000, rd);
      rdchk("sync_and_min_length", A_SYNC, 32'h0000_00ff);
      wr(A_NONE, 32'h0000_00a5);
      rdchk("unmapped", A_NONE, 32'h0000_0000);
      for (int c = 0; c < 4; c++) begin
         wr(A_SYNC, {24'h0, c[1:0], 6'h00});
         settle();
         chk("sync_byte_count", 32'(c + 2), {29'h0, sync_byte_count});
      end
      for (int t = 0; t < 4; t++) begin
         wr(A_DEMOD, {28'h0, t[1:0], ~t[1:0]});
         settle();
         chk("rx_pll_tau", 32'(t), {30'h0, rx_pll_tau});
         chk("rx_pll_freeze", 32'(t == 0), {31'h0, rx_pll_freeze});
         chk("burst_pll_tau", 32'(3 - t), {30'h0, burst_pll_tau});
      end
      // dynamic choice follows the stronger channel both ways
      wr(A_DEMOD, 32'h0000_0000);
      @(posedge ref_clk);
      i_strength <= 8'h40;
      q_strength <= 8'h20;
      chan(0, 0);
      @(posedge ref_clk);
      q_strength <= 8'h60;
      chan(1, 0);
      wr(A_DEMOD, 32'h0000_0080);
      chan(0, 1);
      wr(A_DEMOD, 32'h0000_00a0);
      chan(0, 0);
      wr(A_DEMOD, 32'h0000_0020);
      chan(0, 0);
      @(posedge ref_clk);
      i_strength <= 8'h80;
      wr(A_DEMOD, 32'h0000_0060);
      chan(1, 0);
      // freeze: the choice made before the communication holds while it lasts
      wr(A_DEMOD, 32'h0000_0040);
      @(posedge ref_clk);
      i_strength <= 8'h40;
      chan(1, 0);
      @(posedge ref_clk);
      comm_active <= 1'b1;
      settle();
      @(posedge ref_clk);
      i_strength <= 8'h80;
      chan(1, 0);
      @(posedge ref_clk);
      comm_active <= 1'b0;
      chan(0, 0);
      // minimum length 3 means 12 bytes; then the largest field value
      wr(A_SYNC, 32'h0000_0003);
      pkt(9'd11, 1'b0);
      pkt(9'd12, 1'b1);
      pkt(9'd13, 1'b1);
      wr(A_RXCTX, 32'h0000_0002);
      pkt(9'd4, 1'b1);
      wr(A_RXCTX, 32'h0000_0003);
      pkt(9'd4, 1'b0);
      wr(A_RXCTX, 32'h0000_0000);
      pkt(9'd4, 1'b0);
      wr(A_SYNC, 32'h0000_003f);
      pkt(9'd251, 1'b0);
      pkt(9'd252, 1'b1);
      // four accepted and four discarded so far; i stronger, no freeze, no combine
      rdchk("status", A_STAT, 32'h0004_0400);
      // eight cycles per carrier edge: gaps are 8*(2p+1) or 8*(2p+2)
      wr(A_PRESC, 32'h0000_0002);
      wr(A_DEMOD, 32'h0000_0000);
      tick_gap(32'h0000_0028);
      wr(A_DEMOD, 32'h0000_0010);
      tick_gap(32'h0000_0030);
      wr(A_PRESC, 32'h0000_0000);
      wr(A_DEMOD, 32'h0000_0000);
      tick_gap(32'h0000_0008);
      end_of_test();
   end
endmodule // tb_dsl_config
